//--- ufc_pkg.sv
package ufc_pkg;
	// register offsets
	localparam logic [7:0] OFF_RESUME_ONE  = 8'h0b;
	localparam logic [7:0] OFF_RESUME_TWO  = 8'h0c;
	localparam logic [7:0] OFF_PAUSE_ONE   = 8'h0d;
	localparam logic [7:0] OFF_PAUSE_TWO   = 8'h0e;
	localparam logic [7:0] OFF_ADV_STATUS  = 8'h0f;
	localparam logic [7:0] OFF_TX_IRQ_LVL  = 8'h10;
	localparam logic [7:0] OFF_RX_IRQ_LVL  = 8'h11;
	localparam logic [7:0] OFF_FLOW_LOW    = 8'h12;
	localparam logic [7:0] OFF_FLOW_HIGH   = 8'h13;
	localparam logic [7:0] OFF_PRESCALE    = 8'h14;
	localparam logic [7:0] OFF_RX_COUNT    = 8'h15;
	localparam logic [7:0] OFF_TX_COUNT    = 8'h16;
	// advanced status bit positions
	localparam int ADV_TERM_BIT    = 0;
	localparam int ADV_PAUSED_BIT  = 1;
	localparam int ADV_XONOFF_BIT  = 2;
	localparam int ADV_SPECIAL_BIT = 3;
	// enhanced feature control bit positions
	localparam int EFC_INBAND_LSB  = 2;
	localparam int EFC_ENHANCED    = 4;
	localparam int EFC_SPECIAL_EN  = 5;
	localparam int EFC_AUTO_RTS    = 6;
	// in-band transmit modes
	localparam logic [1:0] INBAND_OFF  = 2'b00;
	localparam logic [1:0] INBAND_TWO  = 2'b01;
	localparam logic [1:0] INBAND_ONE  = 2'b10;
	// prescale field layout
	localparam int PRE_N_LSB = 0;
	localparam int PRE_M_LSB = 4;
	// oversample divisor mapping
	localparam logic [3:0] OVS_CODE_MAX  = 4'hc;
	localparam logic [4:0] OVS_DIV_BASE  = 5'h10;
	localparam logic [3:0] OVS_FIELD_MSK = 4'hf;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_NIB  = 4'h0;
	localparam logic [7:0] RD_IDLE  = 8'h00;
endpackage

//--- ufc_regs.sv
// Behaviour
// - four resume/pause char registers, reset zero
// - status bit0 shows remote terminate condition
// - status bit1 shows pause or RTS stop sent
// - status bit2 resume/pause char seen, read-clear
// - status bit3 special char seen, read-clear
// - detect flags reported as level six interrupt
// - transmit interrupt trigger level register
// - receive interrupt trigger level register
// - low flow threshold releases stopped sender
// - high flow threshold stops remote sender
// - prescale low nibble holds N factor
// - offset 15h muxes rx or line-status count
// - rx count shows receive FIFO entries
// - line-status count shows queue entries
// - offset 16h muxes tx count or oversample
// - tx count shows transmit FIFO entries
// - oversample code maps 16 down to 4
// - auto RTS stops high, releases below low
// - in-band pause/resume inserted on fill crossing
module ufc_regs #(
	parameter int ADDR_W = 8 // register address width
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic [7:0]        enhanced_feature_ctrl,
	input  wire logic              rx_count_select,
	input  wire logic              tx_count_select,
	input  wire logic [7:0]        rx_fill_level,
	input  wire logic [7:0]        line_status_fill,
	input  wire logic [7:0]        tx_fill_level,
	input  wire logic              rx_char_valid,
	input  wire logic [7:0]        rx_char,
	input  wire logic              remote_terminate,
	input  wire logic              pause_special_irq_en,
	input  wire logic              rts_request_n,
	input  wire logic              flow_char_ready,
	output logic                   flow_char_valid,
	output logic      [7:0]        flow_char,
	output logic                   rts_n,
	output logic                   irq_level6,
	output logic                   tx_irq,
	output logic                   rx_irq,
	output logic      [3:0]        prescale_n_factor,
	output logic      [3:0]        prescale_m_factor,
	output logic      [4:0]        oversample_divisor
);
	import ufc_pkg::*;

	// the offsets need five address bits at least; refused while elaborating
	if (ADDR_W < 5 || ADDR_W > 16)
	begin : g_addr_w_check
		$error("ufc_regs: ADDR_W must lie in 5..16");
	end

	// whole state of the block
	typedef struct packed {
		logic [3:0][7:0] chars;       // resume one, two, pause one, two
		logic [7:0]      tx_lvl;      // transmit trigger level
		logic [7:0]      rx_lvl;      // receive trigger level
		logic [7:0]      flow_low;    // release threshold
		logic [7:0]      flow_high;   // stop threshold
		logic [7:0]      prescale;    // M and N factors
		logic [3:0]      ovs_code;    // oversample select code
		logic            det_xonoff;  // resume/pause seen
		logic            det_special; // special char seen
		logic            rts_stop;    // auto RTS holding sender off
		logic            rts_pin;     // registered RTS level
		logic            paused;      // last inserted char was pause
		logic            pend_valid;  // flow char waiting for transmitter
		logic            pend_pause;  // waiting char is a pause
		logic [7:0]      pend_char;   // waiting char value
		logic [7:0]      rdata;       // read data, one cycle
	} ufc_state_t;

	ufc_state_t st;      // registered state
	ufc_state_t next_st; // next state

	// decoded feature controls
	logic       enhanced;   // enhanced mode on
	logic       auto_rts;   // automatic RTS active
	logic [1:0] inband;     // in-band transmit mode
	logic       inband_on;  // in-band flow active
	logic       xonoff_hit; // received char matches a flow char
	logic       special_hit;// received char matches a pause char
	logic       adv_read;   // status register being read
	logic       hold_off;   // sender held off by this device
	logic [7:0] sel_pause;  // pause char of current mode
	logic [7:0] sel_resume; // resume char of current mode

	// address compare against a byte offset
	function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		at = (a == ADDR_W'(off));
	endfunction

	// feature decode and receive comparators
	always_comb
	begin
		enhanced    = enhanced_feature_ctrl[EFC_ENHANCED];
		auto_rts    = enhanced & enhanced_feature_ctrl[EFC_AUTO_RTS];
		inband      = enhanced_feature_ctrl[EFC_INBAND_LSB +: 2];
		// reserved mode 11b acts as disabled
		inband_on   = enhanced & ((inband == INBAND_TWO) | (inband == INBAND_ONE));
		sel_pause   = (inband == INBAND_TWO) ? st.chars[3] : st.chars[2];
		sel_resume  = (inband == INBAND_TWO) ? st.chars[1] : st.chars[0];
		// any of the four flow chars counts as resume/pause seen
		xonoff_hit  = rx_char_valid & enhanced & ((rx_char == st.chars[0]) | (rx_char == st.chars[1]) |
			(rx_char == st.chars[2]) | (rx_char == st.chars[3]));
		// special detection compares against the pause chars only
		special_hit = rx_char_valid & enhanced & enhanced_feature_ctrl[EFC_SPECIAL_EN] &
			((rx_char == st.chars[2]) | (rx_char == st.chars[3]));
		adv_read    = reg_rd & at(reg_addr, OFF_ADV_STATUS);
		hold_off    = (auto_rts & st.rts_stop) | (inband_on & st.paused);
	end

	// next-state logic
	always_comb
	begin
		next_st       = st;
		next_st.rdata = RD_IDLE;

		// register writes; read-only offsets ignore them
		if (reg_wr)
		begin
			if (at(reg_addr, OFF_RESUME_ONE))
				next_st.chars[0] = reg_wdata;
			if (at(reg_addr, OFF_RESUME_TWO))
				next_st.chars[1] = reg_wdata;
			if (at(reg_addr, OFF_PAUSE_ONE))
				next_st.chars[2] = reg_wdata;
			if (at(reg_addr, OFF_PAUSE_TWO))
				next_st.chars[3] = reg_wdata;
			if (at(reg_addr, OFF_TX_IRQ_LVL))
				next_st.tx_lvl = reg_wdata;
			if (at(reg_addr, OFF_RX_IRQ_LVL))
				next_st.rx_lvl = reg_wdata;
			if (at(reg_addr, OFF_FLOW_LOW))
				next_st.flow_low = reg_wdata;
			if (at(reg_addr, OFF_FLOW_HIGH))
				next_st.flow_high = reg_wdata;
			if (at(reg_addr, OFF_PRESCALE))
				next_st.prescale = reg_wdata;
			// oversample register only while the count is not selected
			if (at(reg_addr, OFF_TX_COUNT) && !tx_count_select)
				next_st.ovs_code = reg_wdata[3:0] & OVS_FIELD_MSK;
		end

		// read mux, data stand in the following cycle only
		if (reg_rd)
		begin
			if (at(reg_addr, OFF_RESUME_ONE))
				next_st.rdata = st.chars[0];
			else if (at(reg_addr, OFF_RESUME_TWO))
				next_st.rdata = st.chars[1];
			else if (at(reg_addr, OFF_PAUSE_ONE))
				next_st.rdata = st.chars[2];
			else if (at(reg_addr, OFF_PAUSE_TWO))
				next_st.rdata = st.chars[3];
			else if (at(reg_addr, OFF_ADV_STATUS))
			begin
				// reserved upper nibble reads zero
				next_st.rdata[ADV_TERM_BIT]    = remote_terminate;
				next_st.rdata[ADV_PAUSED_BIT]  = hold_off;
				next_st.rdata[ADV_XONOFF_BIT]  = st.det_xonoff;
				next_st.rdata[ADV_SPECIAL_BIT] = st.det_special;
			end
			else if (at(reg_addr, OFF_TX_IRQ_LVL))
				next_st.rdata = st.tx_lvl;
			else if (at(reg_addr, OFF_RX_IRQ_LVL))
				next_st.rdata = st.rx_lvl;
			else if (at(reg_addr, OFF_FLOW_LOW))
				next_st.rdata = st.flow_low;
			else if (at(reg_addr, OFF_FLOW_HIGH))
				next_st.rdata = st.flow_high;
			else if (at(reg_addr, OFF_PRESCALE))
				next_st.rdata = st.prescale;
			else if (at(reg_addr, OFF_RX_COUNT))
				next_st.rdata = rx_count_select ? rx_fill_level : line_status_fill;
			else if (at(reg_addr, OFF_TX_COUNT))
				next_st.rdata = tx_count_select ? tx_fill_level : {RST_NIB, st.ovs_code};
			else
				next_st.rdata = RD_IDLE; // unmapped reads zero
		end

		// detect flags: a hit in the clearing read wins over the clear
		if (adv_read)
		begin
			next_st.det_xonoff  = 1'b0;
			next_st.det_special = 1'b0;
		end
		if (xonoff_hit)
			next_st.det_xonoff = 1'b1;
		if (special_hit)
			next_st.det_special = 1'b1;

		// auto RTS hysteresis between the two thresholds
		if (!auto_rts)
			next_st.rts_stop = 1'b0;
		else if (rx_fill_level >= st.flow_high)
			next_st.rts_stop = 1'b1;
		else if (rx_fill_level < st.flow_low)
			next_st.rts_stop = 1'b0;
		// auto RTS: inactive high while stopping, active low otherwise; without auto RTS the software level
		next_st.rts_pin = auto_rts ? next_st.rts_stop : rts_request_n;

		// in-band insertion: hand one char at a time to the transmitter
		if (st.pend_valid && flow_char_ready)
		begin
			next_st.pend_valid = 1'b0;
			next_st.paused     = st.pend_pause;
		end
		else if (!st.pend_valid && inband_on)
		begin
			if (!st.paused && rx_fill_level > st.flow_high)
			begin
				next_st.pend_valid = 1'b1;
				next_st.pend_pause = 1'b1;
				next_st.pend_char  = sel_pause;
			end
			else if (st.paused && rx_fill_level < st.flow_low)
			begin
				next_st.pend_valid = 1'b1;
				next_st.pend_pause = 1'b0;
				next_st.pend_char  = sel_resume;
			end
		end
		// leaving in-band mode forgets the pause
		if (!inband_on && !st.pend_valid)
			next_st.paused = 1'b0;
	end

	// state register, synchronous reset
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			st             <= '0;
			st.chars       <= {4{RST_BYTE}};
			st.tx_lvl      <= RST_BYTE;
			st.rx_lvl      <= RST_BYTE;
			st.flow_low    <= RST_BYTE;
			st.flow_high   <= RST_BYTE;
			st.prescale    <= RST_BYTE;
			st.ovs_code    <= RST_NIB;
			st.rts_pin     <= 1'b1;          // safe idle: sender held off
		end
		else
			st <= next_st;
	end

	// outputs
	always_comb
	begin
		reg_rdata         = st.rdata;
		flow_char_valid   = st.pend_valid;
		flow_char         = st.pend_char;
		rts_n             = st.rts_pin;
		irq_level6        = pause_special_irq_en & (st.det_xonoff | st.det_special);
		tx_irq            = (tx_fill_level <= st.tx_lvl);
		rx_irq            = (rx_fill_level >= st.rx_lvl);
		prescale_n_factor = st.prescale[PRE_N_LSB +: 4];
		// M outside 0..2 passes through unchecked
		prescale_m_factor = st.prescale[PRE_M_LSB +: 4];
		// reserved codes fall back to the widest divisor
		if (st.ovs_code <= OVS_CODE_MAX)
			oversample_divisor = OVS_DIV_BASE - {1'b0, st.ovs_code};
		else
			oversample_divisor = OVS_DIV_BASE;
	end

	// assertions
	a_char_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && at(reg_addr, OFF_PAUSE_TWO)) ##1 (reg_rd && at(reg_addr, OFF_PAUSE_TWO) && !reg_wr)
		|=> (reg_rdata == $past(reg_wdata, 2)))
		else $error("pause char two readback wrong");

	a_term_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		adv_read |=> (reg_rdata[ADV_TERM_BIT] == $past(remote_terminate)))
		else $error("terminate bit wrong");

	a_hold_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(adv_read && auto_rts && st.rts_stop) |=> reg_rdata[ADV_PAUSED_BIT])
		else $error("hold-off bit not shown");

	a_xonoff_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(adv_read && !xonoff_hit) |=> !st.det_xonoff)
		else $error("resume/pause detect not cleared by read");

	a_special_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		special_hit |=> (st.det_special && (irq_level6 == pause_special_irq_en || $changed(pause_special_irq_en))))
		else $error("special detect not set");

	a_irq_six: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(xonoff_hit && pause_special_irq_en) ##1 pause_special_irq_en |-> irq_level6)
		else $error("level six interrupt missing after detection");

	a_count_mux: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && at(reg_addr, OFF_RX_COUNT))
		|=> (reg_rdata == ($past(rx_count_select) ? $past(rx_fill_level) : $past(line_status_fill))))
		else $error("offset 15h read wrong");

	a_rts_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(auto_rts && rx_fill_level >= st.flow_high) |=> rts_n)
		else $error("rts not forced inactive at high threshold");

	a_divisor_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st.ovs_code == 4'h3) |-> (oversample_divisor == 5'h0d))
		else $error("oversample divisor mapping wrong");

	a_inband_pause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(inband_on && !st.pend_valid && !st.paused && rx_fill_level > st.flow_high)
		|=> (flow_char_valid && flow_char == $past(sel_pause)))
		else $error("pause char not offered");

	// a new trigger level takes effect on the very next comparison
	a_tx_trigger: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && at(reg_addr, OFF_TX_IRQ_LVL)) |=> (tx_irq == (tx_fill_level <= $past(reg_wdata))))
		else $error("tx interrupt does not follow new trigger level");

	// receive side mirrors the transmit check
	a_rx_trigger: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && at(reg_addr, OFF_RX_IRQ_LVL)) |=> (rx_irq == (rx_fill_level >= $past(reg_wdata))))
		else $error("rx interrupt does not follow new trigger level");

	// any of the four flow chars raises the detect flag
	a_xonoff_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		xonoff_hit |=> st.det_xonoff)
		else $error("resume/pause detect not set");

	// between the thresholds a stop already made stands
	a_low_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(auto_rts && st.rts_stop && rx_fill_level >= st.flow_low) |=> rts_n)
		else $error("rts released above low threshold");

	// release only when fill is below both levels; a crossed pair keeps stopping
	a_rts_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(auto_rts && rx_fill_level < st.flow_low && rx_fill_level < st.flow_high) |=> !rts_n)
		else $error("rts not released below low threshold");

	// resume goes out once the fill has drained past the low level
	a_resume_offer: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(inband_on && !st.pend_valid && st.paused && rx_fill_level < st.flow_low)
		|=> (flow_char_valid && flow_char == $past(sel_resume)))
		else $error("resume char not offered");

	// the transmitter may stall; the offered char must not move meanwhile
	a_offer_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(flow_char_valid && !flow_char_ready) |=> (flow_char_valid && $stable(flow_char)))
		else $error("flow char dropped or changed before acceptance");

	// the N field reaches the baud logic one cycle after the write
	a_prescale_n: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && at(reg_addr, OFF_PRESCALE)) |=> (prescale_n_factor == $past(reg_wdata[3:0])))
		else $error("prescale N factor not taken");

	// with the count selected the sample-clock code is shielded from writes
	a_ovs_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_wr && at(reg_addr, OFF_TX_COUNT) && tx_count_select) |=> $stable(st.ovs_code))
		else $error("oversample code written while count selected");

	// transmit count read back through the shared offset
	a_tx_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && at(reg_addr, OFF_TX_COUNT) && tx_count_select) |=> (reg_rdata == $past(tx_fill_level)))
		else $error("tx count read wrong");

	// receive count read back through the shared offset
	a_rx_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && at(reg_addr, OFF_RX_COUNT) && rx_count_select) |=> (reg_rdata == $past(rx_fill_level)))
		else $error("rx count read wrong");
endmodule

//--- ufc_peer.sv
// far-side serial peer: takes inserted flow chars, sends received chars
module ufc_peer (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] stall,
	input  wire logic       flow_char_valid,
	input  wire logic [7:0] flow_char,
	output logic            flow_char_ready,
	output logic            rx_char_valid,
	output logic [7:0]      rx_char,
	output logic [7:0]      last_taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_cnt = 4'h0; // cycles the offered char has waited
	initial
	begin
		flow_char_ready = 1'b0;
		rx_char_valid   = 1'b0;
		rx_char         = 8'h00;
		last_taken      = 8'h00;
	end
	// a slow transmitter: ready only after stall plus one cycles of valid
	always @(posedge ref_clk)
	begin
		if (flow_char_valid && flow_char_ready)
			last_taken <= flow_char;
		if (!rst_n || flow_char_ready || !flow_char_valid)
		begin
			wait_cnt        <= 4'h0;
			flow_char_ready <= 1'b0;
		end
		else
		begin
			wait_cnt        <= wait_cnt + 4'h1;
			flow_char_ready <= (wait_cnt >= stall);
		end
	end
	// one received char; the idle bus never keeps a stale copy
	task automatic send(input logic [7:0] c);
		@(posedge ref_clk);
		rx_char_valid <= 1'b1;
		rx_char       <= c;
		@(posedge ref_clk);
		rx_char_valid <= 1'b0;
		rx_char       <= ~c;
	endtask
endmodule

//--- ufc_tb.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ufc_pkg::*;
	logic       ref_clk = 1'b0;
	logic       rst_n   = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, efc = 8'h00;
	logic       reg_wr = 1'b0, reg_rd = 1'b0, rx_sel = 1'b0, tx_sel = 1'b0;
	logic [7:0] rx_fill = 8'h00, ls_fill = 8'h00, tx_fill = 8'h00;
	logic       term = 1'b0, irq6_en = 1'b0, rts_req_n = 1'b1;
	logic [3:0] stall = 4'h0;
	logic [7:0] reg_rdata, flow_char, rx_char, last_taken;
	logic       flow_char_valid, flow_char_ready, rx_char_valid, rts_n, irq_level6, tx_irq, rx_irq;
	logic [3:0] pn, pm;
	logic [4:0] ovs;
	int         failures = 0, n_compared = 0, cycles = 0;
	always #10 ref_clk = ~ref_clk; // 50 MHz
	ufc_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enhanced_feature_ctrl(efc),
		.rx_count_select(rx_sel), .tx_count_select(tx_sel), .rx_fill_level(rx_fill),
		.line_status_fill(ls_fill), .tx_fill_level(tx_fill), .rx_char_valid(rx_char_valid),
		.rx_char(rx_char), .remote_terminate(term), .pause_special_irq_en(irq6_en),
		.rts_request_n(rts_req_n), .flow_char_ready(flow_char_ready), .flow_char_valid(flow_char_valid),
		.flow_char(flow_char), .rts_n(rts_n), .irq_level6(irq_level6), .tx_irq(tx_irq), .rx_irq(rx_irq),
		.prescale_n_factor(pn), .prescale_m_factor(pm), .oversample_divisor(ovs));
	ufc_peer peer_u (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall), .flow_char_valid(flow_char_valid),
		.flow_char(flow_char), .flow_char_ready(flow_char_ready), .rx_char_valid(rx_char_valid),
		.rx_char(rx_char), .last_taken(last_taken));
	// hang guard: tests need well under 2000 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, exp, seen);
		end
	endtask
	// checks after a tick read, at the edge, what stood in the cycle before it
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// one-cycle write strobe, no wait state
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe; taken at the edge closing it
	task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		chk(n, reg_rdata, e);
	endtask
	// write, then read back in the very next cycle with no gap
	task automatic wr_rd(input string n, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		chk(n, reg_rdata, e);
	endtask
	task automatic t_regs();
		logic [7:0] a;
		logic [7:0] d;
		for (int i = 0; i < 10; i++)
		begin
			a = OFF_RESUME_ONE + 8'(i);
			d = {4'h2, a[3:0]};
			rc("reset value", a, 8'h00);
			// M factor kept at 2; the status byte is read-only
			wr_rd("read back", a, d, (a == OFF_ADV_STATUS) ? 8'h00 : d);
		end
		tick(1);
		chk("n factor", {4'h0, pn}, 8'h04);
		chk("m factor", {4'h0, pm}, 8'h02);
		wr(OFF_ADV_STATUS, 8'hff);
		rc("status ignores writes", OFF_ADV_STATUS, 8'h00);
		rc("unmapped", 8'h20, 8'h00);
		$display("register test done");
	endtask
	task automatic t_detect();
		@(posedge ref_clk);
		term    <= 1'b1;
		efc     <= 8'h30;
		irq6_en <= 1'b1;
		rc("terminate bit", OFF_ADV_STATUS, 8'h01);
		term <= 1'b0;
		peer_u.send(8'h2d);
		tick(1);
		chk("level six irq", irq_level6, 1'b1);
		rc("pause detect", OFF_ADV_STATUS, 8'h0c);
		rc("read cleared", OFF_ADV_STATUS, 8'h00);
		chk("level six idle", irq_level6, 1'b0);
		irq6_en <= 1'b0;
		peer_u.send(8'h2b);
		tick(1);
		chk("irq masked", irq_level6, 1'b0);
		rc("resume detect", OFF_ADV_STATUS, 8'h04);
		// enhanced mode without special detection: only the flow flag rises
		efc <= 8'h10;
		peer_u.send(8'h2d);
		rc("special disabled", OFF_ADV_STATUS, 8'h04);
		efc <= 8'h00;
		peer_u.send(8'h2e);
		rc("no enhanced mode", OFF_ADV_STATUS, 8'h00);
		$display("detect test done");
	endtask
	task automatic t_counts();
		@(posedge ref_clk);
		rx_fill <= 8'h07;
		ls_fill <= 8'h03;
		tx_fill <= 8'h05;
		rx_sel  <= 1'b1;
		tx_sel  <= 1'b1;
		rc("rx count", OFF_RX_COUNT, 8'h07);
		wr(OFF_TX_COUNT, 8'h0c);
		rc("tx count", OFF_TX_COUNT, 8'h05);
		rx_sel <= 1'b0;
		tx_sel <= 1'b0;
		rc("line status count", OFF_RX_COUNT, 8'h03);
		rc("oversample kept", OFF_TX_COUNT, 8'h00);
		for (int c = 0; c < 16; c++)
		begin
			wr(OFF_TX_COUNT, {4'hf, 4'(c)});
			rc("oversample code", OFF_TX_COUNT, {4'h0, 4'(c)});
			chk("divisor", {3'h0, ovs}, (c <= 12) ? 8'(16 - c) : 8'h10);
		end
		$display("count test done");
	endtask
	task automatic t_rts();
		wr(OFF_FLOW_HIGH, 8'h08);
		wr(OFF_FLOW_LOW, 8'h04);
		efc       <= 8'h50;
		rts_req_n <= 1'b0;
		rx_fill   <= 8'h08;
		tick(3);
		chk("rts stop at high", rts_n, 1'b1);
		rc("stop shown", OFF_ADV_STATUS, 8'h02);
		rx_fill <= 8'h04;
		tick(3);
		chk("rts held at low", rts_n, 1'b1);
		rx_fill <= 8'h03;
		tick(3);
		chk("rts released", rts_n, 1'b0);
		rc("stop cleared", OFF_ADV_STATUS, 8'h00);
		rx_fill <= 8'h07;
		tick(3);
		chk("rts stays released", rts_n, 1'b0);
		efc       <= 8'h00;
		rts_req_n <= 1'b1;
		tick(3);
		chk("software rts", rts_n, 1'b1);
		$display("rts test done");
	endtask
	// mode 10 uses the first char pair, mode 01 the second
	task automatic t_inband();
		for (int m = 0; m < 2; m++)
		begin
			efc     <= m ? 8'h34 : 8'h38;
			stall   <= 4'h3;
			rx_fill <= 8'h08;
			tick(8);
			chk("no pause at high", flow_char_valid, 1'b0);
			rx_fill <= 8'h09;
			tick(14);
			chk("pause sent", last_taken, m ? 8'h2e : 8'h2d);
			chk("valid dropped", flow_char_valid, 1'b0);
			rc("paused shown", OFF_ADV_STATUS, 8'h02);
			rx_fill <= 8'h02;
			tick(14);
			chk("resume sent", last_taken, m ? 8'h2c : 8'h2b);
			rc("paused cleared", OFF_ADV_STATUS, 8'h00);
		end
		efc <= 8'h00;
		$display("in-band test done");
	endtask
	task automatic t_irq();
		wr(OFF_TX_IRQ_LVL, 8'h05);
		wr(OFF_RX_IRQ_LVL, 8'h06);
		tx_fill <= 8'h05;
		rx_fill <= 8'h06;
		tick(2);
		chk("tx irq at level", tx_irq, 1'b1);
		chk("rx irq at level", rx_irq, 1'b1);
		tx_fill <= 8'h06;
		rx_fill <= 8'h05;
		tick(2);
		chk("tx irq above", tx_irq, 1'b0);
		chk("rx irq below", rx_irq, 1'b0);
		$display("irq test done");
	endtask
	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_detect();
		t_counts();
		t_rts();
		t_inband();
		t_irq();
		end_of_test();
	end
endmodule
